// ---- hdl/rcs_delay_timer.sv ----
/*
 Down-counting interval timer: loads a count, runs while enabled, flags done.
 Assumes load and run come from the sequencer in the same clock domain.
*/
`timescale 1ns/1ps
module rcs_delay_timer #(
   parameter int unsigned W = 32
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         resetn,
   // Control
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   input  wire logic         run,
   // Status
   output logic              done
);
   logic [W-1:0] cnt_r;
   wire          atZero = (cnt_r == '0);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r <= '0;
         done  <= 1'b0;
      end
      else if (load)
      begin
         cnt_r <= count;
         done  <= 1'b0;
      end
      else if (run && !atZero)
      begin
         cnt_r <= cnt_r - 1'b1;
         done  <= (cnt_r == W'(1));
      end
      else if (atZero)
         done <= 1'b1;
   end
endmodule : rcs_delay_timer

// ---- hdl/rcs_pkg.sv ----
/*
 Constants, types and register map for the reset and clock start-up sequencer.
 Assumes a single 100 MHz clock and an AXI4-Lite master for register access.
*/
package rcs_pkg;
   localparam int unsigned CLK_MHZ         = 100;
   localparam int unsigned PWRT_MS         = 64;
   localparam int unsigned PWRT_CYC        = PWRT_MS * 1000 * CLK_MHZ;
   localparam int unsigned POR_US          = 10;
   localparam int unsigned POR_CYC         = POR_US * CLK_MHZ;
   localparam int unsigned RST_US          = 10;
   localparam int unsigned RST_CYC         = RST_US * CLK_MHZ;
   localparam int unsigned RCSTART_US      = 1;
   localparam int unsigned RCSTART_CYC     = RCSTART_US * CLK_MHZ;
   localparam int unsigned LOCK_US         = 2;
   localparam int unsigned LOCK_CYC        = LOCK_US * CLK_MHZ;
   localparam int unsigned OST_PERIODS     = 1024;
   localparam int unsigned OST_W           = 10;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] CFG_OFS    = 8'h04;
   localparam logic [7:0] OSC_OFS    = 8'h08;
   localparam logic [7:0] STAT_OFS   = 8'h0C;
   // Field positions
   localparam int unsigned NOSC_LSB  = 8;
   localparam int unsigned CURRENT_OSC_FIELD_LSB  = 12;
   localparam int unsigned CTL_SWEN  = 0;
   localparam int unsigned CTL_TWOSP = 1;
   localparam int unsigned CTL_SWRST = 2;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
   localparam logic [31:0] CFG_RST   = 32'h0000_0700;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_DEC  = 2'h3;

   typedef enum logic [2:0] {
      OSC_FRC, OSC_FAST_RC_WITH_PLL, OSC_PRI, OSC_PRIPLL,
      OSC_SEC, OSC_LOW_POWER_RC, OSC_EXT, OSC_FAST_RC_DIVIDED
   } rcs_osc_t;

   typedef enum logic [1:0] {RT_POR, RT_BOR, RT_OTHER} rcs_rtype_t;

   typedef struct packed {
      logic powerOn;
      logic brownOut;
      logic clearPin;
      logic watchdog;
   } rcs_cause_t;

   typedef struct packed {
      logic frcReady;
      logic lprcReady;
      logic priOscTick;
      logic secOscTick;
      logic pllLocked;
      logic extClockSrc;
   } rcs_clkrdy_t;
endpackage : rcs_pkg

// ---- hdl/rcs_sequencer.sv ----
/*
 Reset and clock start-up sequencer with an AXI4-Lite register slave.
 Assumes reset causes and clock ready indications are synchronous to mclk.
*/
`timescale 1ns/1ps
module rcs_sequencer
   import rcs_pkg::*;
#(
   parameter int unsigned PWRT_CYCLES = rcs_pkg::PWRT_CYC
) (
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               resetn,
   // Reset causes and pins
   input  wire rcs_pkg::rcs_cause_t causes,
   input  wire logic               regulatorEnablePin,
   // Clock source indications
   input  wire rcs_pkg::rcs_clkrdy_t clkRdy,
   // Sequencer outputs
   output logic                    systemMasterResetN,
   output logic [2:0]              sysClockSel,
   output logic                    fetchEnable,
   output logic                    failsafeMonitorEn,
   // AXI4-Lite write address
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [7:0]         s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   // AXI4-Lite write response
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   output logic [1:0]              s_axi_bresp,
   // AXI4-Lite read
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   input  wire logic [7:0]         s_axi_araddr,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp
);
   import rcs_pkg::*;

   typedef enum logic [2:0] {
      SQ_IDLE, SQ_POR, SQ_PWRT, SQ_RST, SQ_RUN
   } rcs_state_t;

   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[8*i +: 8] = nw[8*i +: 8];
      return res;
   endfunction : mergeBytes

   function automatic logic isPll(input logic [2:0] s);
      return (s == OSC_FAST_RC_WITH_PLL) || (s == OSC_PRIPLL);
   endfunction : isPll

   rcs_state_t state_r, state_nxt;
   rcs_rtype_t rtype_r;
   logic [31:0] ctrl_r;
   logic [31:0] cfg_r;
   logic [2:0]  curOsc_r;
   logic [2:0]  selSrc_r;
   logic        swReset_r;
   logic        pending_r;
   logic        clkReady_r;
   logic [OST_W-1:0] ost_r;
   logic        ostDone_r;
   logic        lockSeen_r;
   logic        srcSeen_r;

   // Reset cause detection; power-on has priority, then brown-out
   wire anyCause  = causes.powerOn | causes.brownOut | causes.clearPin | causes.watchdog
                    | swReset_r;
   wire rcs_rtype_t causeType = rcs_rtype_t'(causes.powerOn ? RT_POR :
                                             (causes.brownOut ? RT_BOR : RT_OTHER));
   // Release of the reset pin with no cause pending counts as power-on
   wire rcs_rtype_t selType   = rcs_rtype_t'((pending_r && !anyCause) ? RT_POR : causeType);

   wire swEn       = ctrl_r[CTL_SWEN];
   wire [2:0] cfgOsc = cfg_r[NOSC_LSB +: 3];
   wire [2:0] pickSrc = (!swEn || selType != RT_OTHER) ? cfgOsc : curOsc_r;
   // two-speed start-up begins on fast RC
   // Only cold starts; a warm reset keeps the current source only with CTL_SWEN set
   wire [2:0] startSrc = (ctrl_r[CTL_TWOSP] && selType != RT_OTHER) ? 3'(OSC_FRC) : pickSrc;

   // Interval timers
   logic porDone, pwrtDone, rstDone;
   // Reload on power-up release too, else the first hold would be skipped
   wire  ldTimers = anyCause | pending_r;
   // power-up timer counts PWRT_CYCLES only with regulator disabled; one cycle if enabled
   wire [31:0] pwrtLoad = regulatorEnablePin ? 32'h0000_0001 : 32'(PWRT_CYCLES);

   rcs_delay_timer #(.W(32)) uPor (
      .mclk(mclk), .resetn(resetn), .load(ldTimers), .count(32'(POR_CYC)),
      .run(state_r == SQ_POR), .done(porDone));
   rcs_delay_timer #(.W(32)) uPwrt (
      .mclk(mclk), .resetn(resetn), .load(ldTimers), .count(pwrtLoad),
      .run(state_r == SQ_PWRT), .done(pwrtDone));
   rcs_delay_timer #(.W(32)) uRst (
      .mclk(mclk), .resetn(resetn), .load(ldTimers), .count(32'(RST_CYC)),
      .run(state_r == SQ_RST), .done(rstDone));

   // master reset hold sequence by reset type
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         SQ_IDLE: state_nxt = (rtype_r == RT_POR) ? SQ_POR :
                              (rtype_r == RT_BOR) ? SQ_PWRT : SQ_RST;
         SQ_POR:  if (porDone) state_nxt = SQ_PWRT;
         SQ_PWRT: if (pwrtDone) state_nxt = SQ_RST;
         SQ_RST:  if (rstDone) state_nxt = SQ_RUN;
         default: state_nxt = state_r;
      endcase
   end

   // 10-bit start-up timer on oscillator periods
   wire isCrystal = (selSrc_r == OSC_PRI) || (selSrc_r == OSC_PRIPLL) || (selSrc_r == OSC_SEC);
   wire oscTick   = (selSrc_r == OSC_SEC) ? clkRdy.secOscTick : clkRdy.priOscTick;

   wire baseReady = (selSrc_r == OSC_EXT)  ? 1'b1 :
                    (selSrc_r == OSC_LOW_POWER_RC) ? clkRdy.lprcReady :
                    isCrystal              ? ostDone_r : clkRdy.frcReady;
   // Warm resets count the selected source as ready at once, so they add no clock delay;
   // a warm reset onto a stopped crystal is not covered
   wire srcReady  = (rtype_r == RT_OTHER) ||
                    (baseReady && (!isPll(selSrc_r) || lockSeen_r));

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r  <= SQ_IDLE;
         rtype_r  <= RT_POR;
         selSrc_r <= 3'(OSC_FRC);
         curOsc_r <= 3'(OSC_FRC);
         pending_r <= 1'b1;
      end
      else if (anyCause)
      begin
         state_r  <= SQ_IDLE;
         rtype_r  <= causeType;
         selSrc_r <= startSrc;
         curOsc_r <= startSrc;
         pending_r <= 1'b0;
      end
      else
      begin
         // First reset after power-up is treated as power-on
         state_r  <= pending_r ? SQ_IDLE : state_nxt;
         pending_r <= 1'b0;
         if (pending_r)
         begin
            selSrc_r <= startSrc;
            curOsc_r <= startSrc;
         end
      end
   end

   // start-up timer and PLL lock run beside the reset hold
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         ost_r      <= '0;
         ostDone_r  <= 1'b0;
         lockSeen_r <= 1'b0;
         srcSeen_r  <= 1'b0;
      end
      else if (anyCause || pending_r)
      begin
         ost_r      <= '0;
         ostDone_r  <= 1'b0;
         lockSeen_r <= 1'b0;
         srcSeen_r  <= 1'b0;
      end
      else
      begin
         if (isCrystal && oscTick && !ostDone_r)
         begin
            ost_r <= ost_r + 1'b1;
            ostDone_r <= (ost_r == OST_W'(OST_PERIODS - 1));
         end
         lockSeen_r <= lockSeen_r | clkRdy.pllLocked;
         srcSeen_r  <= srcReady;
      end
   end

   // outputs follow release and clock ready
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         systemMasterResetN <= 1'b0;
         sysClockSel        <= 3'(OSC_FRC);
         fetchEnable        <= 1'b0;
         failsafeMonitorEn  <= 1'b0;
         clkReady_r         <= 1'b0;
      end
      else
      begin
         systemMasterResetN <= (state_r == SQ_RUN) && !anyCause;
         sysClockSel        <= selSrc_r;
         clkReady_r         <= srcSeen_r;
         fetchEnable        <= (state_r == SQ_RUN) && srcSeen_r && !anyCause;
         failsafeMonitorEn  <= systemMasterResetN && (state_r == SQ_RUN) && !anyCause;
      end
   end

   // AXI4-Lite slave: write when address and data both present
   logic awHeld_r, wHeld_r;
   logic [7:0]  awAddr_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;
   wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
   wire wrCtrl  = doWrite && (awAddr_r == CTRL_OFS);
   wire wrCfg   = doWrite && (awAddr_r == CFG_OFS);
   wire wrHit   = (awAddr_r == CTRL_OFS) || (awAddr_r == CFG_OFS);
   wire [31:0] ctrlMerged = mergeBytes(ctrl_r, wData_r, wStrb_r);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         awHeld_r      <= 1'b0;
         wHeld_r       <= 1'b0;
         awAddr_r      <= '0;
         wData_r       <= '0;
         wStrb_r       <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OK;
         ctrl_r        <= CTRL_RST;
         cfg_r         <= CFG_RST;
         swReset_r     <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_r      <= 1'b1;
            awAddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         swReset_r <= wrCtrl && ctrlMerged[CTL_SWRST];
         if (doWrite)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? RESP_OK : RESP_DEC;
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         // Software reset bit is self-clearing
         if (wrCtrl)
            ctrl_r <= ctrlMerged & ~(32'h1 << CTL_SWRST);
         if (wrCfg)
            cfg_r <= mergeBytes(cfg_r, wData_r, wStrb_r) & CFG_RST;
      end
   end

   // Read path
   wire [31:0] statWord = {24'h0, clkReady_r, fetchEnable, failsafeMonitorEn,
                           systemMasterResetN, 1'b0, rtype_r, 1'b0};
   wire [31:0] rdMux = (s_axi_araddr == CTRL_OFS) ? ctrl_r :
                       (s_axi_araddr == CFG_OFS)  ? cfg_r :
                       (s_axi_araddr == OSC_OFS)  ? (32'(curOsc_r) << CURRENT_OSC_FIELD_LSB) :
                       (s_axi_araddr == STAT_OFS) ? statWord : 32'h0;
   wire rdHit = (s_axi_araddr == CTRL_OFS) || (s_axi_araddr == CFG_OFS) ||
                (s_axi_araddr == OSC_OFS)  || (s_axi_araddr == STAT_OFS);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OK;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rdMux;
         s_axi_rresp   <= rdHit ? RESP_OK : RESP_DEC;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule : rcs_sequencer

// ---- verification/rcs_clock_sources.sv ----
/*
 Behavioural clock sources facing the sequencer's clock-ready inputs.
 Assumes the bench raises restart whenever power is reapplied.
*/
`timescale 1ns/1ps
module rcs_clock_sources
   import rcs_pkg::*;
(
   // Clock and restart
   input  wire logic            mclk,
   input  wire logic            restart,
   // Ready indications
   output wire rcs_pkg::rcs_clkrdy_t clkRdy
);
   logic [12:0] age_r;
   logic [1:0]  phase_r;

   // Age saturates so readiness never drops between restarts
   always_ff @(posedge mclk)
   begin
      phase_r <= restart ? 2'h0 : phase_r + 2'h1;
      age_r   <= restart ? 13'h0 : age_r + {12'h0, ~&age_r};
   end
   assign clkRdy.frcReady    = !restart && age_r > 13'h1E;
   assign clkRdy.lprcReady   = !restart && age_r > 13'h3C;
   assign clkRdy.priOscTick  = phase_r[0];
   assign clkRdy.secOscTick  = &phase_r;
   assign clkRdy.pllLocked   = !restart && age_r > 13'h12C;
   assign clkRdy.extClockSrc = 1'h1;
endmodule : rcs_clock_sources

// ---- verification/rcs_sequencer_asserts.sv ----
/*
 Port-level checks of the reset and clock start-up sequencer.
 Bound into every rcs_sequencer instance; sees only its ports.
*/
`timescale 1ns/1ps
module rcs_sequencer_asserts
   import rcs_pkg::*;
#(
   parameter int unsigned PWRT_CYCLES = 50
) (
   // Clock, reset and causes
   input wire logic                 mclk,
   input wire logic                 resetn,
   input wire rcs_pkg::rcs_cause_t  causes,
   input wire logic                 regulatorEnablePin,
   input wire rcs_pkg::rcs_clkrdy_t clkRdy,
   // Sequencer outputs
   input wire logic                 systemMasterResetN,
   input wire logic [2:0]           sysClockSel,
   input wire logic                 fetchEnable,
   input wire logic                 failsafeMonitorEn,
   // Register bus
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_awready,
   input wire logic [7:0]           s_axi_awaddr,
   input wire logic                 s_axi_wvalid,
   input wire logic                 s_axi_wready,
   input wire logic [31:0]          s_axi_wdata,
   input wire logic [3:0]           s_axi_wstrb,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic [1:0]           s_axi_bresp,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic [7:0]           s_axi_araddr,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_rready,
   input wire logic [31:0]          s_axi_rdata,
   input wire logic [1:0]           s_axi_rresp
);
   import rcs_pkg::*;
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!resetn);
   wire logic anyCause = |causes;

   property p_fetch_gate; fetchEnable |-> systemMasterResetN; endproperty
   a_fetch_gate: assert property (p_fetch_gate) else $error("fetch while held");
   property p_mon_gate; failsafeMonitorEn |-> systemMasterResetN; endproperty
   a_mon_gate: assert property (p_mon_gate) else $error("monitor while held");
   property p_mon_late; $rose(failsafeMonitorEn) |-> $past(systemMasterResetN); endproperty
   a_mon_late: assert property (p_mon_late) else $error("monitor too early");
   property p_cause_hold; anyCause |-> ##[1:2] !systemMasterResetN; endproperty
   a_cause_hold: assert property (p_cause_hold) else $error("cause not held");
   property p_state_tmr; causes.watchdog |-> ##2 !systemMasterResetN [*8]; endproperty
   a_state_tmr: assert property (p_state_tmr) else $error("state timer skipped");
   property p_rel_delay; $rose(systemMasterResetN) |-> !$past(systemMasterResetN, 8); endproperty
   a_rel_delay: assert property (p_rel_delay) else $error("release too soon");
   property p_sel_keep; fetchEnable && $past(fetchEnable) |-> $stable(sysClockSel); endproperty
   a_sel_keep: assert property (p_sel_keep) else $error("source changed in run");
   property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("late read answer");
   property p_wr_block; s_axi_bvalid |-> !s_axi_awready; endproperty
   a_wr_block: assert property (p_wr_block) else $error("address taken early");

   c_fetch: cover property ($rose(fetchEnable));
   c_mon: cover property ($rose(failsafeMonitorEn));
   c_dec: cover property (s_axi_bvalid && s_axi_bresp == RESP_DEC);
endmodule : rcs_sequencer_asserts

bind rcs_sequencer rcs_sequencer_asserts #(.PWRT_CYCLES(PWRT_CYCLES)) i_rcs_sequencer_asserts (
   .mclk(mclk), .resetn(resetn), .causes(causes), .regulatorEnablePin(regulatorEnablePin),
   .clkRdy(clkRdy), .systemMasterResetN(systemMasterResetN), .sysClockSel(sysClockSel),
   .fetchEnable(fetchEnable), .failsafeMonitorEn(failsafeMonitorEn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

// ---- verification/reset_clock_startup_sequencer_tb.sv ----
/*
 Self-checking bench: reset sequences, clock choice and register access.
 Assumes rcs_sequencer and the behavioural clock sources.
*/
`timescale 1ns/1ps
module reset_clock_startup_sequencer_tb;
   import rcs_pkg::*;
   localparam int PW = 50;
   logic mclk = 1'h0, resetn = 1'h0, regulatorEnablePin = 1'h0, restart = 1'h1;
   rcs_cause_t causes = '0;
   rcs_clkrdy_t clkRdy;
   logic systemMasterResetN, fetchEnable, failsafeMonitorEn;
   logic [2:0] sysClockSel;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int num_errors = 0, tests_run = 0;

   rcs_sequencer #(.PWRT_CYCLES(PW)) i_rcs_sequencer (
      .mclk(mclk), .resetn(resetn), .causes(causes), .regulatorEnablePin(regulatorEnablePin),
      .clkRdy(clkRdy), .systemMasterResetN(systemMasterResetN), .sysClockSel(sysClockSel),
      .fetchEnable(fetchEnable), .failsafeMonitorEn(failsafeMonitorEn),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
   rcs_clock_sources i_rcs_clock_sources (.mclk(mclk), .restart(restart), .clkRdy(clkRdy));

   always #5 mclk = ~mclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge mclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid && n < 50);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      check(n < 50, 1'h1);
      @(posedge mclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge mclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid && n < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      check(n < 50, 1'h1);
      @(posedge mclk);
   endtask : rd

   // Source chosen at release: k 0 power-on, 1 brown-out, 2..3 pin/watchdog, 4 software
   function automatic logic [2:0] exp_sel(int k, logic [31:0] ctl, logic [2:0] s, logic [2:0] c);
      if (ctl[1] && k < 2) return OSC_FRC;
      return (!ctl[0] || k < 2) ? s : c;
   endfunction : exp_sel

   // Clock delay of the partner's sources; none after warm resets
   function automatic int exp_clk(int k, logic [2:0] e);
      if (k > 1 || e == OSC_EXT) return 0;
      case (e)
         OSC_PRI, OSC_PRIPLL: return 2048;
         OSC_SEC: return 4096;
         OSC_FAST_RC_WITH_PLL: return 301;
         OSC_LOW_POWER_RC: return 61;
         default: return 31;
      endcase
   endfunction : exp_clk

   task automatic hit(input int k, output int hold, output int go);
      causes <= rcs_cause_t'(4'h8 >> k);
      restart <= k < 2;
      @(posedge mclk);
      causes <= '0;
      restart <= 1'h0;
      hold = 0;
      do
      begin
         @(posedge mclk);
         hold++;
      end while ((!systemMasterResetN || hold < 4) && hold < 9000);
      go = hold;
      while (!fetchEnable && go < 12000)
      begin
         @(posedge mclk);
         go++;
      end
   endtask : hit

   task automatic run(input int k, input logic [2:0] s, input logic [31:0] ctl);
      logic [31:0] d;
      logic [1:0] r;
      logic [2:0] e;
      int hold, go, eh, cd;
      wr(CFG_OFS, {21'h0, s, 8'h0}, r);
      wr(CTRL_OFS, ctl, r);
      rd(OSC_OFS, d, r);
      e = exp_sel(k, ctl, s, d[14:12]);
      eh = (k == 0 ? POR_CYC : 0) + (k < 2 ? (regulatorEnablePin ? 1 : PW) : 0) + RST_CYC;
      if (k == 4) wr(CTRL_OFS, ctl | 32'h4, r);
      hit(k, hold, go);
      // Monitor enable follows release by one edge
      @(posedge mclk);
      cd = exp_clk(k, e);
      cd = cd > hold ? cd : hold;
      check(hold + 8 >= eh && hold <= eh + 8, 1'h1);
      check(sysClockSel, e);
      check(go + 40 >= cd && go <= cd + 40, 1'h1);
      check(failsafeMonitorEn, 1'h1);
      rd(STAT_OFS, d, r);
      check(d, {24'h0, 5'h1E, 2'(k < 2 ? k : 2), 1'h0});
      $display("Test done: reset %0d source %0d", k, s);
   endtask : run

   initial
   begin
      logic [31:0] d;
      logic [1:0] r;
      void'($urandom(19933));
      repeat (4) @(posedge mclk);
      resetn <= 1'h1;
      rd(CTRL_OFS, d, r);
      check(d, CTRL_RST);
      rd(CFG_OFS, d, r);
      check(d, CFG_RST);
      rd(8'h10, d, r);
      check(r, RESP_DEC);
      wr(STAT_OFS, 32'h0, r);
      check(r, RESP_DEC);
      run(0, 3'h7, CTRL_RST);
      run(4, OSC_PRI, 32'h1);
      run(2, OSC_LOW_POWER_RC, 32'h0);
      run(3, OSC_EXT, 32'h1);
      run(0, OSC_PRI, 32'h3);
      regulatorEnablePin <= 1'h1;
      run(1, OSC_SEC, 32'h1);
      regulatorEnablePin <= 1'h0;
      repeat (8) run($urandom % 5, 3'($urandom), {31'h0, 1'($urandom)});
      complete_run();
   end

   // Fourteen sequences of at most about 5000 cycles each
   initial
   begin
      #800000;
      num_errors++;
      complete_run();
   end
endmodule : reset_clock_startup_sequencer_tb
